// ==== verilog/pptx_defines.svh ====
// constants for the parallel transmit port: codes, layout and timing
`ifndef PPTX_DEFINES_SVH
`define PPTX_DEFINES_SVH

// power state codes
`define PPTX_PS_FULL       2'h0
`define PPTX_PS_QUICK      2'h1
`define PPTX_PS_DEEP       2'h2

// timing
`define PPTX_CLK_MHZ       25
`define PPTX_DEEP_EXIT_US  64
`define PPTX_DEEP_EXIT_CYC (`PPTX_DEEP_EXIT_US * `PPTX_CLK_MHZ)
`define PPTX_DONE_CYC      8
`define PPTX_TXCLK_HALF    4
`define PPTX_TXCLK_MID     2
`define PPTX_STRAP_WAIT    2'h2

// link sync vector layout
`define PPTX_SY_CLK        0
`define PPTX_SY_IDLE       1
`define PPTX_SY_PS_LO      2
`define PPTX_SY_PS_HI      3
`define PPTX_SY_K0         4
`define PPTX_SY_K1         5
`define PPTX_SY_D_LO       6
`define PPTX_SY_D_HI       21
`define PPTX_SY_W          22

// controller register map
`define PPTX_REG_CTRL      4'h0
`define PPTX_REG_STATUS    4'h4
`define PPTX_REG_TXDATA    4'h8
`define PPTX_ST_DONE       0
`define PPTX_ST_FULL       1
`define PPTX_ST_DDR        2
`define PPTX_TXD_K_LO      16
`define PPTX_TXD_K_HI      17

`endif

// ==== verilog/pptx_pkg.sv ====
// types shared by both ends of the parallel transmit port
`include "pptx_defines.svh"

package pptx_pkg;

  typedef logic [1:0] pptx_pstate_t;

  typedef enum logic [2:0] {
    PPTX_PM_RUN  = 3'h1,
    PPTX_PM_WAIT = 3'h2,
    PPTX_PM_DONE = 3'h4
  } pptx_pm_t;

endpackage : pptx_pkg

// ==== verilog/pptx_if.sv ====
// link between the controller end and the phy end
`timescale 1ns/1ps

interface pptx_if;
  logic        tx_clk;
  logic [15:0] tx_data;
  logic [1:0]  tx_symbol_kind;
  logic [1:0]  power_state_select;
  logic        tx_idle_force;
  logic        phy_done_flag;

  modport phy (
    input  tx_clk,
    input  tx_data,
    input  tx_symbol_kind,
    input  power_state_select,
    input  tx_idle_force,
    output phy_done_flag
  );

  modport mac (
    output tx_clk,
    output tx_data,
    output tx_symbol_kind,
    output power_state_select,
    output tx_idle_force,
    input  phy_done_flag
  );
endinterface : pptx_if

// ==== verilog/pptx_phy.sv ====
// phy end of the parallel transmit port with its symbol fifo
// Function
// R1 - code 10: deep sleep, exit within 64 us
// R2 - done flag marks finished phy operations
// R3 - strap low: capture 16 bits, rising edges
// R4 - single rate: low byte first, high second
// R5 - strap high: low byte on both edges
// R6 - double rate: rising byte first, falling second
// R7 - double rate: controller grounds upper data byte
// R8 - single rate: kind bit per byte
// R9 - double rate: kind bit 0 only, bit 1 grounded
// R10 - kind zero data, kind one control
// R11 - code 00 full power, 01 quick sleep
// R12 - async low reset, strap taken at release
// R13 - idle force low means data valid
// R14 - done pulse after power change takes effect
`timescale 1ns/1ps
`include "pptx_defines.svh"

// ****************************************************************
// symbol fifo
// ****************************************************************
module pptx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : pptx_fifo

// ****************************************************************
// phy end
// ****************************************************************
module pptx_phy
  import pptx_pkg::*;
#(
  parameter int DEPTH    = 16,
  parameter int WAKE_CYC = `PPTX_DEEP_EXIT_CYC
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ddr_strap_i,
  pptx_if.phy               link,
  output      logic [7:0]   sym_data_o,
  output      logic         sym_kind_o,
  output      logic         sym_valid_o,
  input  wire logic         sym_ready_i,
  output      pptx_pstate_t power_state_o,
  output      logic         ddr_mode_o,
  output      logic         overflow_o
);
  logic [`PPTX_SY_W-1:0] sy1;
  logic [`PPTX_SY_W-1:0] sy2;
  logic                  strap1;
  logic                  strap2;
  logic                  clk_d;
  logic                  rise;
  logic                  fall;
  logic [1:0]            strap_cnt;
  logic                  mode_ok;
  logic                  ddr_mode;
  logic                  cap_en;
  logic [8:0]            stage0;
  logic [8:0]            stage1;
  logic [1:0]            stage_cnt;
  logic                  fifo_ready;
  logic                  fifo_valid;
  logic [8:0]            fifo_data;
  pptx_pm_t              pm;
  pptx_pstate_t          target;
  logic [31:0]           wait_cnt;
  logic [3:0]            done_cnt;
  pptx_pstate_t          ps_req;

  // ****************************************************************
  // pin synchronisers and link clock edges
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sy1    <= '0;
      sy2    <= '0;
      strap1 <= 1'b0;
      strap2 <= 1'b0;
      clk_d  <= 1'b0;
    end else begin
      sy1    <= {link.tx_data, link.tx_symbol_kind, link.power_state_select,
                 link.tx_idle_force, link.tx_clk};
      sy2    <= sy1;
      strap1 <= ddr_strap_i;
      strap2 <= strap1;
      clk_d  <= sy2[`PPTX_SY_CLK];
    end
  end

  assign rise   = sy2[`PPTX_SY_CLK] & ~clk_d;
  assign fall   = ~sy2[`PPTX_SY_CLK] & clk_d;
  assign ps_req = sy2[`PPTX_SY_PS_HI:`PPTX_SY_PS_LO];

  // ****************************************************************
  // rate strap, caught once the synchroniser has settled after release
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt <= 2'h0;
      mode_ok   <= 1'b0;
      ddr_mode  <= 1'b0;
    end else if (!mode_ok) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == `PPTX_STRAP_WAIT) begin // see R12
        ddr_mode <= strap2;
        mode_ok  <= 1'b1;
      end
    end
  end

  assign ddr_mode_o = ddr_mode;

  // ****************************************************************
  // symbol capture and staging
  // ****************************************************************
  // only full power with idle force low carries data
  assign cap_en = mode_ok && (power_state_o == `PPTX_PS_FULL)
                  && !sy2[`PPTX_SY_IDLE]; // see R13 see R11

  // a capture while staging is still busy means the fifo stayed full
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage0     <= '0;
      stage1     <= '0;
      stage_cnt  <= 2'h0;
      overflow_o <= 1'b0;
    end else if (cap_en && !ddr_mode && rise) begin
      // kind bit travels with its byte: 0 data, 1 control
      stage0     <= {sy2[`PPTX_SY_K0], sy2[`PPTX_SY_D_LO+7:`PPTX_SY_D_LO]}; // see R3 see R8 see R10
      stage1     <= {sy2[`PPTX_SY_K1], sy2[`PPTX_SY_D_HI:`PPTX_SY_D_LO+8]}; // see R4
      stage_cnt  <= 2'h2;
      overflow_o <= overflow_o | (stage_cnt != 2'h0);
    end else if (cap_en && ddr_mode && (rise || fall)) begin
      // upper byte and kind bit 1 are ignored here
      stage0     <= {sy2[`PPTX_SY_K0], sy2[`PPTX_SY_D_LO+7:`PPTX_SY_D_LO]}; // see R5 see R9 see R7
      stage_cnt  <= 2'h1; // see R6
      overflow_o <= overflow_o | (stage_cnt != 2'h0);
    end else if ((stage_cnt != 2'h0) && fifo_ready) begin
      stage0    <= stage1;
      stage_cnt <= stage_cnt - 2'h1;
    end
  end

  pptx_fifo #(
    .WIDTH (9),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (stage_cnt != 2'h0),
    .in_ready_o  (fifo_ready),
    .in_data_i   (stage0),
    .out_valid_o (fifo_valid),
    .out_ready_i (sym_ready_i),
    .out_data_o  (fifo_data)
  );

  assign sym_valid_o = fifo_valid;
  assign sym_kind_o  = fifo_data[8];
  assign sym_data_o  = fifo_data[7:0];

  // ****************************************************************
  // power state machine
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pm            <= PPTX_PM_RUN;
      target        <= `PPTX_PS_FULL;
      power_state_o <= `PPTX_PS_FULL;
      wait_cnt      <= '0;
      done_cnt      <= '0;
    end else begin
      case (pm)
        PPTX_PM_RUN: begin
          if (mode_ok && ps_req != power_state_o) begin
            target <= ps_req;
            pm     <= PPTX_PM_WAIT;
            // leaving deep sleep takes the wake time, all else one cycle
            wait_cnt <= (power_state_o == `PPTX_PS_DEEP) ? 32'(WAKE_CYC - 1) : '0; // see R1
          end
        end
        PPTX_PM_WAIT: begin
          if (wait_cnt == '0) begin
            power_state_o <= target;
            done_cnt      <= 4'(`PPTX_DONE_CYC - 1);
            pm            <= PPTX_PM_DONE;
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        PPTX_PM_DONE: begin
          if (done_cnt == '0) begin
            pm <= PPTX_PM_RUN;
          end else begin
            done_cnt <= done_cnt - 4'h1;
          end
        end
        default: begin
          pm <= PPTX_PM_RUN;
        end
      endcase
    end
  end

  // held for one link clock period so the far end can see it
  assign link.phy_done_flag = (pm == PPTX_PM_DONE); // see R2 see R14
endmodule : pptx_phy

// ==== verilog/pptx_mac.sv ====
// controller end of the parallel transmit port
`timescale 1ns/1ps
`include "pptx_defines.svh"

module pptx_mac
  import pptx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ddr_strap_i,
  pptx_if.mac              link,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output      logic [31:0] rdata_o
);
  logic [1:0]   div_cnt;
  logic         tclk;
  logic         slot;
  logic         strap1;
  logic         strap2;
  logic [1:0]   strap_cnt;
  logic         mode_ok;
  logic         ddr_mode;
  logic [17:0]  hold;
  logic         hold_full;
  logic         second;
  logic         consume;
  pptx_pstate_t ps_reg;
  logic         done1;
  logic         done2;
  logic         done_d;
  logic         done_sticky;
  logic         done_clr;

  // ****************************************************************
  // link clock divider, data moves one clk_i cycle before a link edge
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 2'h0;
      tclk    <= 1'b0;
    end else if (div_cnt == 2'(`PPTX_TXCLK_HALF - 1)) begin
      div_cnt <= 2'h0;
      tclk    <= ~tclk;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  assign link.tx_clk = tclk;
  assign slot        = mode_ok && (div_cnt == 2'(`PPTX_TXCLK_MID)) && (ddr_mode || !tclk);

  // strap is a pin: two flops, then taken a fixed count after release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap1 <= 1'b0;
      strap2 <= 1'b0;
    end else begin
      strap1 <= ddr_strap_i;
      strap2 <= strap1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt <= 2'h0;
      mode_ok   <= 1'b0;
      ddr_mode  <= 1'b0;
    end else if (!mode_ok) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == `PPTX_STRAP_WAIT) begin
        ddr_mode <= strap2; // see R12
        mode_ok  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // bus drive
  // ****************************************************************
  // double rate sends the low byte before the rising edge, high after it
  // a word leaves only at full power; in double rate only after its low byte went out
  assign consume = slot && hold_full
                   && (ddr_mode ? (tclk && second) : (ps_reg == `PPTX_PS_FULL));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.tx_data        <= '0;
      link.tx_symbol_kind <= '0;
      link.tx_idle_force  <= 1'b1;
      second              <= 1'b0;
    end else if (slot && !ddr_mode) begin
      link.tx_data        <= hold[15:0]; // see R4 see R8 see R10
      link.tx_symbol_kind <= hold[`PPTX_TXD_K_HI:`PPTX_TXD_K_LO];
      link.tx_idle_force  <= !(hold_full && ps_reg == `PPTX_PS_FULL); // see R13
    end else if (slot && !tclk) begin
      link.tx_data        <= {8'h00, hold[7:0]}; // see R6 see R7
      link.tx_symbol_kind <= {1'b0, hold[`PPTX_TXD_K_LO]}; // see R9
      link.tx_idle_force  <= !(hold_full && ps_reg == `PPTX_PS_FULL);
      second              <= hold_full && ps_reg == `PPTX_PS_FULL;
    end else if (slot) begin
      link.tx_data        <= {8'h00, hold[15:8]};
      link.tx_symbol_kind <= {1'b0, hold[`PPTX_TXD_K_HI]};
      second              <= 1'b0;
    end
  end

  assign link.power_state_select = ps_reg; // see R1 see R11

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ps_reg <= `PPTX_PS_FULL;
    end else if (wr_i && addr_i == `PPTX_REG_CTRL) begin
      ps_reg <= wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold      <= '0;
      hold_full <= 1'b0;
    end else if (consume) begin
      hold_full <= 1'b0;
    end else if (wr_i && addr_i == `PPTX_REG_TXDATA && !hold_full) begin
      hold      <= wdata_i[17:0];
      hold_full <= 1'b1;
    end
  end

  // done flag crosses in, rising edge sets the sticky bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done1  <= 1'b0;
      done2  <= 1'b0;
      done_d <= 1'b0;
    end else begin
      done1  <= link.phy_done_flag;
      done2  <= done1;
      done_d <= done2;
    end
  end

  assign done_clr = wr_i && addr_i == `PPTX_REG_STATUS && wdata_i[`PPTX_ST_DONE];

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_sticky <= 1'b0;
    end else if (done2 && !done_d) begin
      done_sticky <= 1'b1; // see R2 see R14
    end else if (done_clr) begin
      done_sticky <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (rd_i && addr_i == `PPTX_REG_CTRL) begin
      rdata_o <= {30'h0, ps_reg};
    end else if (rd_i && addr_i == `PPTX_REG_STATUS) begin
      rdata_o <= {29'h0, ddr_mode, hold_full | second, done_sticky};
    end else if (rd_i && addr_i == `PPTX_REG_TXDATA) begin
      rdata_o <= {14'h0, hold};
    end else begin
      rdata_o <= '0;
    end
  end
endmodule : pptx_mac

// ==== sim/pptx_assertions.sv ====
// checker on the link between the two ends
`timescale 1ns/1ps

module pptx_assertions #(
  parameter int WAKE_CYC = 16
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        tx_clk,
  input wire logic [15:0] tx_data,
  input wire logic [1:0]  tx_symbol_kind,
  input wire logic [1:0]  power_state_select,
  input wire logic        tx_idle_force,
  input wire logic        phy_done_flag,
  input wire logic        ddr_mode_o
);
  localparam int DEEP_MAX = WAKE_CYC + 12;
  logic [1:0] last_pss;
  logic [7:0] since_chg;

  // ****************
  // helper
  // ****************
  // saturates so an old change never looks recent
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_pss  <= 2'h0;
      since_chg <= 8'hFF;
    end else begin
      last_pss <= power_state_select;
      if (power_state_select != last_pss) begin
        since_chg <= 8'h00;
      end else if (since_chg != 8'hFF) begin
        since_chg <= since_chg + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_done_pulse;
    phy_done_flag [*8] ##1 !phy_done_flag;
  endsequence
  sequence s_half_period;
    $stable(tx_clk) [*3] ##1 $changed(tx_clk);
  endsequence

  // ****************
  // properties
  // ****************
  a_done_width: assert property ($rose(phy_done_flag) |-> s_done_pulse)
    else $error("done pulse width wrong");
  a_done_cause: assert property ($rose(phy_done_flag) |-> since_chg <= DEEP_MAX)
    else $error("done without power change");
  a_change_done: assert property (($changed(power_state_select)
      && $past(power_state_select) != 2'h2) |-> ##[2:12] $rose(phy_done_flag))
    else $error("power change not completed");
  a_deep_exit: assert property (($changed(power_state_select)
      && $past(power_state_select) == 2'h2) |-> ##[2:DEEP_MAX] $rose(phy_done_flag))
    else $error("deep sleep exit too slow");
  a_edge_data: assert property ($changed(tx_clk) |-> $stable(tx_data) ##1 $stable(tx_data))
    else $error("data moves at link edge");
  a_edge_kind: assert property ($changed(tx_clk) |->
      $stable(tx_symbol_kind) ##1 $stable(tx_symbol_kind))
    else $error("kind moves at link edge");
  a_ddr_ground: assert property ((ddr_mode_o && !tx_idle_force) |->
      (tx_data[15:8] == 8'h00 && !tx_symbol_kind[1]))
    else $error("upper lane not grounded");
  a_clk_period: assert property ($changed(tx_clk) |=> s_half_period)
    else $error("link half period wrong");
endmodule : pptx_assertions

// ==== sim/phy_parallel_tx_port_tb.sv ====
// bench joining the controller end and the phy end
`timescale 1ns/1ps
`include "pptx_defines.svh"

module phy_parallel_tx_port_tb
  import pptx_pkg::*;
;
  localparam int WAKE = 16;
  logic         clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic         ddr_strap_i = 1'b0;
  logic [3:0]   addr_i = 4'h0;
  logic [31:0]  wdata_i = 32'h0;
  logic         wr_i = 1'b0;
  logic         rd_i = 1'b0;
  logic [31:0]  rdata_o;
  logic [7:0]   sym_data_o;
  logic         sym_kind_o;
  logic         sym_valid_o;
  logic         sym_ready_i = 1'b0;
  pptx_pstate_t power_state_o;
  logic         ddr_mode_o;
  logic         overflow_o;
  logic [8:0]   exp_q[$];
  logic [31:0]  st;
  int           n_fail = 0;
  int           checks_done = 0;
  int           cycles = 0;

  pptx_if pptx_if_inst ();
  pptx_mac pptx_mac_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ddr_strap_i(ddr_strap_i),
    .link(pptx_if_inst.mac), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o));
  pptx_phy #(.DEPTH(16), .WAKE_CYC(WAKE)) pptx_phy_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ddr_strap_i(ddr_strap_i), .link(pptx_if_inst.phy), .sym_data_o(sym_data_o),
    .sym_kind_o(sym_kind_o), .sym_valid_o(sym_valid_o), .sym_ready_i(sym_ready_i),
    .power_state_o(power_state_o), .ddr_mode_o(ddr_mode_o), .overflow_o(overflow_o));
  pptx_assertions #(.WAKE_CYC(WAKE)) pptx_assertions_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .tx_clk(pptx_if_inst.tx_clk), .tx_data(pptx_if_inst.tx_data),
    .tx_symbol_kind(pptx_if_inst.tx_symbol_kind),
    .power_state_select(pptx_if_inst.power_state_select),
    .tx_idle_force(pptx_if_inst.tx_idle_force), .phy_done_flag(pptx_if_inst.phy_done_flag),
    .ddr_mode_o(ddr_mode_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ****************
  // tasks
  // ****************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_sym(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t sym %h exp %h", $time, got, exp);
    end
  endtask : cmp_sym

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : reg_rd

  task automatic do_reset(input logic strap);
    @(posedge clk_i);
    rst_n_i     <= 1'b0;
    ddr_strap_i <= strap;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : do_reset

  // waits out a pending word, a write into a full holder is dropped
  task automatic send_words(input int n, input logic [7:0] base);
    logic [31:0] w;
    int          k;
    for (int i = 0; i < n; i++) begin
      w = {14'h0, 2'(i), 8'(base + 2 * i + 1), 8'(base + 2 * i)};
      k = 0;
      do begin
        reg_rd(`PPTX_REG_STATUS, st);
        k++;
      end while (st[`PPTX_ST_FULL] !== 1'b0 && k < 40);
      reg_wr(`PPTX_REG_TXDATA, w);
      exp_q.push_back({w[`PPTX_TXD_K_LO], w[7:0]});
      exp_q.push_back({w[`PPTX_TXD_K_HI], w[15:8]});
    end
  endtask : send_words

  task automatic drain(input int n);
    int k;
    #1;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (sym_valid_o !== 1'b1 && k < 60) begin
        @(posedge clk_i);
        #1;
        k++;
      end
      cmp_sym({sym_kind_o, sym_data_o}, exp_q.pop_front());
      @(posedge clk_i);
      sym_ready_i <= 1'b1;
      @(posedge clk_i);
      sym_ready_i <= 1'b0;
      #1;
    end
  endtask : drain

  task automatic flush();
    exp_q.delete();
    @(posedge clk_i);
    sym_ready_i <= 1'b1;
    repeat (60) @(posedge clk_i);
    sym_ready_i <= 1'b0;
    #1;
    cmp_word({31'h0, sym_valid_o}, 32'h0);
  endtask : flush

  task automatic set_power(input logic [1:0] code);
    int k;
    reg_wr(`PPTX_REG_CTRL, {30'h0, code});
    k = 0;
    do begin
      reg_rd(`PPTX_REG_STATUS, st);
      k++;
    end while (st[`PPTX_ST_DONE] !== 1'b1 && k < 60);
    cmp_word({31'h0, st[`PPTX_ST_DONE]}, 32'h1);
    cmp_word({30'h0, power_state_o}, {30'h0, code});
    // clear only after the pulse is over, only its rising edge wins over a clear
    repeat (10) @(posedge clk_i);
    reg_wr(`PPTX_REG_STATUS, 32'h1);
    reg_rd(`PPTX_REG_STATUS, st);
    cmp_word({31'h0, st[`PPTX_ST_DONE]}, 32'h0);
  endtask : set_power

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ****************
  // tests
  // ****************
  initial begin
    do_reset(1'b0);
    reg_rd(`PPTX_REG_CTRL, st);
    cmp_word(st, 32'h0);
    reg_rd(`PPTX_REG_STATUS, st);
    cmp_word(st, 32'h0);
    reg_rd(4'hC, st);
    cmp_word(st, 32'h0);
    cmp_word({29'h0, overflow_o, ddr_mode_o, sym_valid_o}, 32'h0);
    $display("test reset done");
    send_words(4, 8'h10);
    drain(8);
    reg_rd(`PPTX_REG_TXDATA, st);
    cmp_word(st, 32'h00031716);
    $display("test single rate done");
    send_words(10, 8'h60);
    repeat (20) @(posedge clk_i);
    cmp_word({31'h0, overflow_o}, 32'h1);
    drain(16);
    flush();
    $display("test overflow done");
    set_power(`PPTX_PS_QUICK);
    send_words(1, 8'h40);
    repeat (40) @(posedge clk_i);
    cmp_word({31'h0, sym_valid_o}, 32'h0);
    set_power(`PPTX_PS_FULL);
    flush();
    set_power(`PPTX_PS_DEEP);
    set_power(`PPTX_PS_FULL);
    $display("test power done");
    do_reset(1'b1);
    reg_rd(`PPTX_REG_STATUS, st);
    cmp_word(st, 32'h4);
    cmp_word({30'h0, overflow_o, ddr_mode_o}, 32'h1);
    send_words(4, 8'hA0);
    drain(8);
    $display("test double rate done");
    tally_and_finish();
  end
endmodule : phy_parallel_tx_port_tb
